// file: design/pds_seq.sv
// Data set sequencer top: AXI4-Lite settings, conditions and step control
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module pds_seq #(
    parameter int ADDR_W = 8,
    parameter int CYC_PER_MS = pds_pkg::CYC_PER_MS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic step_trigger_input,
    input wire logic position_select_input,
    output logic move_valid,
    output logic signed [31:0] move_target,
    output logic move_relative,
    output logic [15:0] move_speed,
    output logic [3:0] move_manner,
    output logic step_valid,
    output logic [3:0] step_set,
    output logic [1:0] seq_state
);
    import pds_pkg::*;

    // ==========================================================
    // Declarations
    logic signed [15:0] fine;
    logic signed [15:0] coarse;
    logic [15:0] speed;
    logic [15:0] attr;
    logic [15:0] cval1;
    logic [15:0] cval2;
    logic [3:0] follow;
    logic [1:0] type_own;
    logic [1:0] type_next;
    logic signed [31:0] target;
    pds_state_e state;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic next_aw_held;
    logic next_w_held;
    logic next_bvalid;
    logic next_rvalid;
    logic [15:0] cur16;
    logic [15:0] wv;
    logic wr_ok;
    logic [31:0] rd_val;
    logic rd_ok;
    logic start;
    logic stop;
    logic arm;
    logic step_ok;
    logic [1:0] met;
    logic [3:0] ctype [2];
    logic [15:0] cval [2];
    logic trig [2];
    logic [3:0] log_sel;

    // ==========================================================
    // Write channel handshakes, one write under way at a time
    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;
    assign do_write = aw_held & w_held & ~s_axi_bvalid;
    assign next_aw_held = (aw_held & ~do_write) | aw_hs;
    assign next_w_held = (w_held & ~do_write) | w_hs;
    assign next_bvalid = (s_axi_bvalid & ~s_axi_bready) | do_write;

    // Address and data are taken in either order and held until the write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            if (aw_hs) aw_addr <= 8'(s_axi_awaddr);
            if (w_hs) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // Ready and response flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= ~next_aw_held & ~next_bvalid;
            s_axi_wready <= ~next_w_held & ~next_bvalid;
            s_axi_bvalid <= next_bvalid;
            if (do_write) s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Current value at the write address, merged with the byte lanes
    always_comb begin
        cur16 = '0;
        wr_ok = 1'b1;
        case (aw_addr)
            OFS_FINE: cur16 = fine;
            OFS_COARSE: cur16 = coarse;
            OFS_SPEED: cur16 = speed;
            OFS_ATTR: cur16 = attr;
            OFS_CVAL1: cur16 = cval1;
            OFS_CVAL2: cur16 = cval2;
            OFS_FOLLOW: cur16 = {12'h000, follow};
            OFS_TYPE_OWN: cur16 = {14'h0000, type_own};
            OFS_TYPE_NEXT: cur16 = {14'h0000, type_next};
            OFS_CTRL: cur16 = '0;
            default: wr_ok = 1'b0;
        endcase
        wv = cur16;
        if (w_strb[0]) wv[7:0] = w_data[7:0];
        if (w_strb[1]) wv[15:8] = w_data[15:8];
    end

    // ==========================================================
    // Settings; a value outside its range leaves the setting unchanged
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fine <= '0;
            coarse <= '0;
            speed <= RST_SPEED;
            attr <= RST_ATTR;
            cval1 <= RST_CVAL;
            cval2 <= RST_CVAL;
            follow <= RST_FOLLOW;
            type_own <= RST_TYPE;
            type_next <= RST_TYPE;
        end else if (do_write) begin
            case (aw_addr)
                OFS_FINE: if ($signed(wv) >= PART_MIN && $signed(wv) <= PART_MAX) fine <= wv;
                OFS_COARSE: if ($signed(wv) >= PART_MIN && $signed(wv) <= PART_MAX) coarse <= wv;
                OFS_SPEED: if (wv <= SPEED_MAX) speed <= wv;
                OFS_ATTR: attr <= wv;
                OFS_CVAL1: cval1 <= wv;
                OFS_CVAL2: cval2 <= wv;
                OFS_FOLLOW: if (wv <= FOLLOW_MAX) follow <= wv[3:0];
                OFS_TYPE_OWN: if (wv <= TYPE_MAX) type_own <= wv[1:0];
                OFS_TYPE_NEXT: if (wv <= TYPE_MAX) type_next <= wv[1:0];
                default: ;
            endcase
        end
    end

    // Control strobes from the control register
    assign start = do_write & (aw_addr == OFS_CTRL) & w_strb[0] & w_data[CTRL_START];
    assign stop = do_write & (aw_addr == OFS_CTRL) & w_strb[0] & w_data[CTRL_STOP];

    // ==========================================================
    // Read channel
    assign ar_hs = s_axi_arvalid & s_axi_arready;
    assign next_rvalid = (s_axi_rvalid & ~s_axi_rready) | ar_hs;

    // Read mux; unmapped addresses answer SLVERR with zero data
    always_comb begin
        rd_val = '0;
        rd_ok = 1'b1;
        case (8'(s_axi_araddr))
            OFS_FINE: rd_val = 32'(fine);
            OFS_COARSE: rd_val = 32'(coarse);
            OFS_SPEED: rd_val = {16'h0000, speed};
            OFS_ATTR: rd_val = {16'h0000, attr};
            OFS_CVAL1: rd_val = {16'h0000, cval1};
            OFS_CVAL2: rd_val = {16'h0000, cval2};
            OFS_FOLLOW: rd_val = {28'h0000000, follow};
            OFS_TYPE_OWN: rd_val = {30'h00000000, type_own};
            OFS_TYPE_NEXT: rd_val = {30'h00000000, type_next};
            OFS_CTRL: rd_val = '0;
            OFS_STATUS: rd_val = {28'h0000000, state, met};
            OFS_TARGET: rd_val = target;
            default: rd_ok = 1'b0;
        endcase
    end

    // Read answer flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (ar_hs) begin
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // Target and conditions
    pds_target u_target (
        .aclk(aclk),
        .aresetn(aresetn),
        .fine(fine),
        .coarse(coarse),
        .target(target)
    );

    assign arm = (state == ST_RUN);
    assign ctype[0] = attr[ATTR_C1_LSB +: 4];
    assign ctype[1] = attr[ATTR_C2_LSB +: 4];
    assign cval[0] = cval1;
    assign cval[1] = cval2;
    assign trig[0] = step_trigger_input;
    assign trig[1] = position_select_input;
    assign log_sel = attr[ATTR_LOG_LSB +: 4];

    // One evaluator per condition
    for (genvar i = 0; i < 2; i++) begin : g_cond
        pds_cond #(.CYC_PER_MS(CYC_PER_MS)) u_cond (
            .aclk(aclk),
            .aresetn(aresetn),
            .arm(arm),
            .cond_type(ctype[i]),
            .cond_value(cval[i]),
            .trigger(trig[i]),
            .met(met[i])
        );
    end

    // Combining logic of the two conditions
    always_comb begin
        case (log_sel)
            LOG_NONE: step_ok = met[0];
            LOG_AND: step_ok = met[0] & met[1];
            LOG_OR: step_ok = met[0] | met[1];
            default: step_ok = 1'b0;
        endcase
    end

    // ==========================================================
    // Sequencer: issue the move, wait for the step, hand over or hold
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            move_valid <= 1'b0;
            move_target <= '0;
            move_relative <= 1'b0;
            move_speed <= '0;
            move_manner <= '0;
            step_valid <= 1'b0;
            step_set <= '0;
        end else begin
            move_valid <= 1'b0;
            step_valid <= 1'b0;
            if (stop) begin
                state <= ST_IDLE;
            end else if (start || (state == ST_STEP && follow == OWN_SET)) begin
                if (type_own == SET_NULL) begin
                    state <= ST_IDLE;
                end else begin
                    state <= ST_RUN;
                    move_valid <= 1'b1;
                    move_target <= target;
                    move_relative <= (type_own == SET_REL);
                    move_speed <= speed;
                    move_manner <= attr[ATTR_MAN_LSB +: 4];
                end
            end else begin
                case (state)
                    ST_RUN: begin
                        if (step_ok) begin
                            state <= ST_STEP;
                            step_valid <= 1'b1;
                            step_set <= follow;
                        end
                    end
                    ST_STEP: begin
                        if (follow == NEXT_SET && type_next == SET_NULL) state <= ST_HOLD;
                        else state <= ST_IDLE;
                    end
                    ST_IDLE, ST_HOLD: ;
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    assign seq_state = state;

    // ==========================================================
    // Checks
    chk_target_sum: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(move_valid) && $stable(fine) && $stable(coarse) |-> move_target == 32'(coarse) * 32'sd10000 + 32'(fine))
        else $error("move target not fine plus coarse times ten thousand");
    chk_null_start: assert property (@(posedge aclk) disable iff (!aresetn)
        (start && !stop && type_own == SET_NULL) |=> !move_valid && state == ST_IDLE)
        else $error("null data set started a move");
    chk_attr_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(!aresetn) |-> attr == 16'h0000 && follow == 4'h7)
        else $error("attribute or follow-up wrong after reset");
    chk_no_cond_step: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_RUN && !start && !stop && log_sel == LOG_NONE && ctype[0] == COND_NONE)
        |=> step_valid ##1 (state != ST_RUN || follow == OWN_SET || $past(start)))
        else $error("unconditional step did not fire");
    chk_and_logic: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_RUN && log_sel == LOG_AND && !(met[0] && met[1])) |=> !step_valid)
        else $error("AND step fired with one condition false");
    chk_manner_out: assert property (@(posedge aclk) disable iff (!aresetn)
        move_valid && $stable(attr) |-> move_manner == attr[15:12])
        else $error("move manner does not follow attribute");
    chk_cval_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(!aresetn) |-> cval1 == 16'h0000 && cval2 == 16'h0000)
        else $error("condition values not zero after reset");
    chk_follow_out: assert property (@(posedge aclk) disable iff (!aresetn)
        step_valid |-> step_set == $past(follow) && state == ST_STEP)
        else $error("step set differs from follow-up number");
    chk_hold_null: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_STEP && !start && !stop && follow == 4'h7 && type_next == SET_NULL)
        |=> state == ST_HOLD ##1 (state == ST_HOLD || $past(start) || $past(stop)))
        else $error("null follow-up set did not hold");
endmodule

// file: design/pds_pkg.sv
// Package: constants and types for the position data set sequencer
package pds_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_FINE = 8'h00;
    localparam logic [7:0] OFS_COARSE = 8'h04;
    localparam logic [7:0] OFS_SPEED = 8'h08;
    localparam logic [7:0] OFS_ATTR = 8'h0c;
    localparam logic [7:0] OFS_CVAL1 = 8'h10;
    localparam logic [7:0] OFS_CVAL2 = 8'h14;
    localparam logic [7:0] OFS_FOLLOW = 8'h18;
    localparam logic [7:0] OFS_TYPE_OWN = 8'h1c;
    localparam logic [7:0] OFS_TYPE_NEXT = 8'h20;
    localparam logic [7:0] OFS_CTRL = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [7:0] OFS_TARGET = 8'h2c;
    // ==========================================================
    // Values after reset and legal ranges
    localparam logic [15:0] RST_SPEED = 16'h0064;
    localparam logic [15:0] RST_ATTR = 16'h0000;
    localparam logic [15:0] RST_CVAL = 16'h0000;
    localparam logic [3:0] RST_FOLLOW = 4'h7;
    localparam logic [1:0] RST_TYPE = 2'h0;
    localparam logic signed [15:0] PART_MAX = 16'sh270f;
    localparam logic signed [15:0] PART_MIN = -16'sh270f;
    localparam logic signed [15:0] COARSE_SCALE = 16'sh2710;
    localparam logic [15:0] SPEED_MAX = 16'h1770;
    localparam logic [15:0] FOLLOW_MAX = 16'h000e;
    localparam logic [15:0] TYPE_MAX = 16'h0002;
    localparam logic [3:0] OWN_SET = 4'h6;
    localparam logic [3:0] NEXT_SET = 4'h7;
    // ==========================================================
    // Field positions
    localparam int ATTR_C1_LSB = 0;
    localparam int ATTR_C2_LSB = 4;
    localparam int ATTR_LOG_LSB = 8;
    localparam int ATTR_MAN_LSB = 12;
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int DELAY_UNIT_NS = 1000000;
    localparam int CYC_PER_MS = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ==========================================================
    // Encodings
    localparam logic [15:0] EDGE_RISE = 16'h0000;
    localparam logic [15:0] EDGE_FALL = 16'h0001;
    localparam logic [15:0] EDGE_ANY = 16'h0002;
    localparam logic [15:0] LEVEL_HIGH = 16'h0003;
    localparam logic [15:0] LEVEL_LOW = 16'h0004;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {SET_NULL = 2'h0, SET_ABS = 2'h1, SET_REL = 2'h2} pds_type_e;
    typedef enum logic [3:0] {COND_NONE = 4'h0, COND_DELAY = 4'h1, COND_EDGE = 4'h2, COND_LEVEL = 4'h3} pds_cond_e;
    typedef enum logic [3:0] {LOG_NONE = 4'h0, LOG_AND = 4'h1, LOG_OR = 4'h2} pds_logic_e;
    typedef enum logic [3:0] {MAN_ABORT = 4'h0, MAN_STANDARD = 4'h1, MAN_BUFFERED = 4'h2, MAN_BLEND_LOW = 4'h3,
        MAN_BLEND_PREV = 4'h4, MAN_BLEND_NEXT = 4'h5, MAN_BLEND_HIGH = 4'h6} pds_manner_e;
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_STEP = 2'b11, ST_HOLD = 2'b10} pds_state_e;
endpackage

// file: design/pds_cond.sv
// One step change condition: none, delay, trigger edge or trigger level
`timescale 1ns/1ns
module pds_cond #(
    parameter int CYC_PER_MS = pds_pkg::CYC_PER_MS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic arm,
    input wire logic [3:0] cond_type,
    input wire logic [15:0] cond_value,
    input wire logic trigger,
    output logic met
);
    import pds_pkg::*;
    logic trig_prev;
    logic hit;
    logic edge_now;
    logic level_now;
    logic [31:0] tick;
    logic [15:0] ms_count;

    // Edge selection and level selection from the condition value
    always_comb begin
        edge_now = 1'b0;
        level_now = 1'b0;
        case (cond_value)
            EDGE_RISE: edge_now = trigger & ~trig_prev;
            EDGE_FALL: edge_now = ~trigger & trig_prev;
            EDGE_ANY: edge_now = trigger ^ trig_prev;
            LEVEL_HIGH: level_now = trigger;
            LEVEL_LOW: level_now = ~trigger;
            default: ;
        endcase
    end

    // Condition result per type; unknown types never fire
    always_comb begin
        case (cond_type)
            COND_NONE: met = arm;
            COND_DELAY: met = arm & (ms_count >= cond_value);
            COND_EDGE: met = arm & (hit | edge_now);
            COND_LEVEL: met = arm & level_now;
            default: met = 1'b0;
        endcase
    end

    // Previous trigger sample, kept also while disarmed
    always_ff @(posedge aclk) begin
        if (!aresetn) trig_prev <= 1'b0;
        else trig_prev <= trigger;
    end

    // Edge stays caught until disarmed, so AND with a later condition works
    always_ff @(posedge aclk) begin
        if (!aresetn || !arm) hit <= 1'b0;
        else if (edge_now) hit <= 1'b1;
    end

    // Millisecond timer, restarts on each arming
    always_ff @(posedge aclk) begin
        if (!aresetn || !arm) begin
            tick <= '0;
            ms_count <= '0;
        end else if (tick == 32'(CYC_PER_MS - 1)) begin
            tick <= '0;
            if (ms_count != 16'hffff) ms_count <= ms_count + 16'h0001;
        end else begin
            tick <= tick + 32'h0000_0001;
        end
    end

    chk_rise_edge: assert property (@(posedge aclk) disable iff (!aresetn)
        (arm && cond_type == COND_EDGE && cond_value == EDGE_RISE && trigger && !trig_prev) |-> met)
        else $error("rising edge did not satisfy condition");
    chk_level_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (cond_type == COND_LEVEL && cond_value == LEVEL_LOW && trigger) |-> !met)
        else $error("level low condition met with input high");
    chk_delay_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        (cond_type == COND_DELAY && ms_count < cond_value) |-> !met)
        else $error("delay condition met before time elapsed");
endmodule

// file: design/pds_target.sv
// Target position from fine and coarse parts
`timescale 1ns/1ns
module pds_target (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic signed [15:0] fine,
    input wire logic signed [15:0] coarse,
    output logic signed [31:0] target
);
    import pds_pkg::*;
    logic signed [31:0] scaled;

    // Coarse part counts ten thousand pulses
    assign scaled = coarse * COARSE_SCALE;

    // Registered sum, one cycle behind the settings
    always_ff @(posedge aclk) begin
        if (!aresetn) target <= '0;
        else target <= scaled + 32'(fine);
    end
endmodule

// file: tb/pds_trig_model.sv
// Trigger input model: step trigger and position select lines
`timescale 1ns/1ns
module pds_trig_model (
    input wire logic aclk,
    output logic step_trigger_input,
    output logic position_select_input
);
    logic step_lvl = 1'b0;
    logic sel_lvl = 1'b0;
    // ==========================================================
    // Lines change only just after a rising edge
    initial begin
        step_trigger_input = 1'b0;
        position_select_input = 1'b0;
    end
    always @(posedge aclk) begin
        step_trigger_input <= step_lvl;
        position_select_input <= sel_lvl;
    end
    // Set the levels that the next edge puts on the lines
    task set_lines(input logic s, input logic p);
        step_lvl <= s;
        sel_lvl <= p;
    endtask
endmodule

// file: tb/pds_seq_tb.sv
// Testbench for the position data set sequencer
`timescale 1ns/1ns
module pds_seq_tb;
    import pds_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic stp, sel, move_valid, move_relative, step_valid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, move_manner, step_set;
    logic [1:0] bresp, rresp, seq_state;
    logic signed [31:0] move_target;
    logic [15:0] move_speed;
    int error_cnt = 0;
    int check_count = 0;
    int mv_cnt = 0;
    int st_cnt = 0;
    pds_seq #(.CYC_PER_MS(4)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .step_trigger_input(stp), .position_select_input(sel), .move_valid(move_valid),
        .move_target(move_target), .move_relative(move_relative), .move_speed(move_speed),
        .move_manner(move_manner), .step_valid(step_valid), .step_set(step_set), .seq_state(seq_state));
    pds_trig_model model (.aclk(aclk), .step_trigger_input(stp), .position_select_input(sel));
    // ==========================================================
    // Clock and pulse counters
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (move_valid === 1'b1) mv_cnt <= mv_cnt + 1;
        if (step_valid === 1'b1) st_cnt <= st_cnt + 1;
    end
    // ==========================================================
    // Compare, bus tasks and verdict
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awvalid === 1'b1 && awready === 1'b1) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid === 1'b1 && wready === 1'b1) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, e);
        chk(32'(rresp), 32'(er));
        @(posedge aclk);
    endtask
    task go;
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
    endtask
    // Arm with levels l0 {step, select}, then move to l1; step counts expected after each
    task trial(input logic [31:0] at, input logic [1:0] l0, input int e0, input logic [1:0] l1, input int e1);
        int s;
        wr(OFS_ATTR, at, RESP_OKAY);
        model.set_lines(l0[1], l0[0]);
        repeat (3) @(posedge aclk);
        s = st_cnt;
        go;
        repeat (6) @(posedge aclk);
        chk(st_cnt - s, e0);
        model.set_lines(l1[1], l1[0]);
        repeat (6) @(posedge aclk);
        chk(st_cnt - s, e1);
    endtask
    task test_done;
        if (error_cnt == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        test_done;
    end
    // ==========================================================
    // Main sequence
    initial begin
        int m, n;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_ATTR, 32'h0, RESP_OKAY);
        rd(OFS_CVAL1, 32'h0, RESP_OKAY);
        rd(OFS_CVAL2, 32'h0, RESP_OKAY);
        rd(OFS_FOLLOW, 32'h7, RESP_OKAY);
        rd(OFS_TYPE_OWN, 32'h0, RESP_OKAY);
        wr(8'h40, 32'h1, RESP_SLVERR);
        rd(8'hfc, 32'h0, RESP_SLVERR);
        wr(OFS_FINE, 32'hfffffffb, RESP_OKAY);
        wr(OFS_COARSE, 32'h3, RESP_OKAY);
        rd(OFS_TARGET, 32'd29995, RESP_OKAY);
        wr(OFS_FINE, 32'd10000, RESP_OKAY);
        rd(OFS_FINE, 32'hfffffffb, RESP_OKAY);
        wr(OFS_FINE, 32'hffffd8f1, RESP_OKAY);
        wr(OFS_COARSE, 32'hffffd8f1, RESP_OKAY);
        wr(OFS_FOLLOW, 32'hf, RESP_OKAY);
        rd(OFS_FOLLOW, 32'h7, RESP_OKAY);
        wr(OFS_TYPE_OWN, 32'h3, RESP_OKAY);
        rd(OFS_TYPE_OWN, 32'h0, RESP_OKAY);
        wr(OFS_TYPE_OWN, 32'h2, RESP_OKAY);
        for (m = 0; m < 7; m++) begin
            wr(OFS_ATTR, 32'(m) << 12, RESP_OKAY);
            n = mv_cnt;
            go;
            repeat (4) @(posedge aclk);
            chk(mv_cnt - n, 1);
            chk(32'(move_manner), m);
            chk(32'(move_relative), 1);
            chk(32'(move_speed), 32'(RST_SPEED));
            chk(move_target, 32'hfa0a1f01);
            chk(32'(step_set), 7);
            chk(32'(seq_state), 2);
        end
        wr(OFS_TYPE_OWN, 32'h1, RESP_OKAY);
        go;
        repeat (2) @(posedge aclk);
        chk(32'(move_relative), 0);
        wr(OFS_CVAL1, 32'h0, RESP_OKAY);
        trial(32'h0002, 2'b10, 0, 2'b00, 0);
        trial(32'h0002, 2'b00, 0, 2'b10, 1);
        wr(OFS_CVAL1, 32'h1, RESP_OKAY);
        trial(32'h0002, 2'b00, 0, 2'b10, 0);
        trial(32'h0002, 2'b10, 0, 2'b00, 1);
        wr(OFS_CVAL1, 32'h2, RESP_OKAY);
        trial(32'h0002, 2'b00, 0, 2'b10, 1);
        wr(OFS_CVAL1, 32'h3, RESP_OKAY);
        wr(OFS_CVAL2, 32'h0, RESP_OKAY);
        trial(32'h0123, 2'b10, 0, 2'b11, 1);
        wr(OFS_CVAL2, 32'h4, RESP_OKAY);
        trial(32'h0133, 2'b11, 0, 2'b10, 1);
        trial(32'h0233, 2'b01, 0, 2'b00, 1);
        trial(32'h0033, 2'b00, 0, 2'b10, 1);
        chk(32'(seq_state), 2);
        wr(OFS_CVAL1, 32'h2, RESP_OKAY);
        trial(32'h0001, 2'b00, 0, 2'b00, 1);
        rd(OFS_STATUS, 32'h8, RESP_OKAY);
        wr(OFS_ATTR, 32'h0, RESP_OKAY);
        wr(OFS_TYPE_NEXT, 32'h1, RESP_OKAY);
        go;
        repeat (3) @(posedge aclk);
        chk(32'(seq_state), 0);
        // Follow-up set 6 reruns its own set until a stop
        wr(OFS_FOLLOW, 32'h6, RESP_OKAY);
        n = mv_cnt;
        go;
        repeat (8) @(posedge aclk);
        chk(32'(mv_cnt - n > 2), 1);
        wr(OFS_CTRL, 32'h2, RESP_OKAY);
        n = mv_cnt;
        repeat (4) @(posedge aclk);
        chk(mv_cnt - n, 0);
        chk(32'(seq_state), 0);
        test_done;
    end
endmodule
